// ### dps_chk_sva.sv
// Purpose: wire-level checks of the three-wire load link
// Assumes: host and device both design ends, sampled on the 200 MHz clock
// Notes:   interval figure is 605 cycles between any two wire changes
`timescale 1ns/10ps
`default_nettype none
module dps_chk_sva
  import dps_pkg::*;
(
  input wire logic clk,          // host clock
  input wire logic rst,          // async reset, active high
  input wire logic load_enable,  // frame framing
  input wire logic shift_strobe, // link clock
  input wire logic serial_in     // serial data
);
  logic       le_q;
  logic       st_q;
  logic       di_q;
  logic [9:0] gap_q;
  logic [5:0] bits_q;
  dps_word_t  word_q;
  logic       chg;

  assign chg = (load_enable != le_q) || (shift_strobe != st_q) || (serial_in != di_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      le_q <= 1'b0;
      st_q <= 1'b0;
      di_q <= 1'b0;
    end else begin
      le_q <= load_enable;
      st_q <= shift_strobe;
      di_q <= serial_in;
    end
  end

  // saturates high so the first change after reset passes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) gap_q <= 10'h3ff;
    else if (chg) gap_q <= 10'h000;
    else if (gap_q != 10'h3ff) gap_q <= gap_q + 10'h001;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) bits_q <= 6'h00;
    else if (!load_enable) bits_q <= 6'h00;
    else if (shift_strobe && !st_q) bits_q <= bits_q + 6'h01;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) word_q <= '0;
    else if (load_enable && shift_strobe && !st_q) word_q <= {serial_in, word_q[47:1]};
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  gap_min_a: assert property (chg |-> gap_q >= 10'd604)
    else $error("link wire changed too soon");
  strobe_in_frame_a: assert property (shift_strobe |-> load_enable)
    else $error("strobe high outside frame");
  data_steady_a: assert property (shift_strobe |-> $stable(serial_in))
    else $error("data moved while strobe high");
  bit_count_a: assert property ((le_q && !load_enable) |-> bits_q == 6'd48)
    else $error("frame did not carry 48 bits");
  div_range_a: assert property ((le_q && !load_enable) |-> word_q[15:0] >= 16'h0100 && word_q[31:16] >= 16'h0100)
    else $error("divider setting below 256");
  factory_zero_a: assert property ((le_q && !load_enable) |-> word_q[47:46] == 2'b00)
    else $error("factory bits not zero");
  frame_end_a: assert property ($fell(load_enable) |-> !shift_strobe && !$past(shift_strobe))
    else $error("frame closed with strobe high");
  frame_start_a: assert property ($rose(load_enable) |-> !shift_strobe [*8])
    else $error("strobe rose right after frame open");
endmodule
`default_nettype wire

// ### dps_defs.svh
// Purpose: constants of the dual synthesizer serial control
// Assumes: 200 MHz clk stands in for the crystal reference
// Notes:   field positions index the 48-bit load word, bit 0 first on the wire
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH

`define DPS_CLK_NS        5
`define DPS_WORD_BITS     48
// load word field positions
`define DPS_TXDIV_LSB     0
`define DPS_RXDIV_LSB     16
`define DPS_REF_LSB       32
`define DPS_THR_LSB       37
`define DPS_HOLD_BIT      40
`define DPS_DZ_LSB        41
`define DPS_TXFL_BIT      43
`define DPS_RXFL_BIT      44
`define DPS_FLALL_BIT     45
`define DPS_FACT_LSB      46
// reference divider, and the tx/rx divider floor
`define DPS_REF_CODE_HI   5'h1f
`define DPS_REF_RATIO_LO  11'd2047
`define DPS_REF_RATIO_HI  11'd1699
`define DPS_DIV_MIN       16'h0100
// phase-error thresholds in ns, 12.8 MHz and 10.625 MHz columns
`define DPS_THR_A1_NS     150
`define DPS_THR_A2_NS     300
`define DPS_THR_A4_NS     1250
`define DPS_THR_A6_NS     5000
`define DPS_THR_B1_NS     190
`define DPS_THR_B4_NS     940
`define DPS_THR_B6_NS     4700
// unlock extension in us
`define DPS_EXT_SHORT_US  2500
`define DPS_EXT_LONG_US   5000
// dead-zone widths in cycles
`define DPS_DZ_SMALL_CYC  11'd1
`define DPS_DZ_MED_CYC    11'd4
`define DPS_DZ_LARGE_CYC  11'd8
// serial interval: 32 periods of a 10.625 MHz crystal, the slower case
`define DPS_T_IFACE_NS    3020
`define DPS_T_IFACE_CYC   (((`DPS_T_IFACE_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS) + 1)

`endif

// ### dps_device.sv
// Purpose: synthesizer end: serial load, dividers, phase detectors, unlock, fast-lock
// Assumes: clk is the crystal reference; oscillator inputs are much slower than clk
// Notes:   all pin outputs stay undriven until the first complete load
`include "dps_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module dps_device
  import dps_pkg::*;
#(
  parameter int EXT_SHORT_CYC = `DPS_EXT_SHORT_US * 1000 / `DPS_CLK_NS,  // 2.5 ms extension
  parameter int EXT_LONG_CYC  = `DPS_EXT_LONG_US * 1000 / `DPS_CLK_NS,   // 5 ms extension
  parameter bit XTAL_LOW      = 1'b0                                      // 1: 10.625 MHz column
) (
  input  wire logic clk,              // crystal reference clock
  input  wire logic rst,              // async reset, active high
  dps_if.dev        link,             // three-wire programming link
  input  wire logic tx_osc_in,        // transmit oscillator pin
  input  wire logic rx_osc_in,        // receive oscillator pin
  output logic      tx_pd_main_out,   // tx main detector level
  output logic      tx_pd_main_oe,    // tx main detector drive enable
  output logic      rx_pd_main_out,   // rx main detector level
  output logic      rx_pd_main_oe,    // rx main detector drive enable
  output logic      tx_pd_aux_out,    // tx aux detector level
  output logic      tx_pd_aux_oe,     // tx aux detector drive enable
  output logic      rx_pd_aux_out,    // rx aux detector level
  output logic      rx_pd_aux_oe,     // rx aux detector drive enable
  output logic      tx_unlock_n_out,  // tx unlock open drain, always 0
  output logic      tx_unlock_n_oe,   // tx unlock pull-down enable
  output logic      rx_unlock_n_out,  // rx unlock open drain, always 0
  output logic      rx_unlock_n_oe,   // rx unlock pull-down enable
  output logic      tx_fastlock_rc_out, // tx fast-lock open drain, always 0
  output logic      tx_fastlock_rc_oe,  // tx fast-lock pull-down enable
  output logic      rx_fastlock_rc_out, // rx fast-lock open drain, always 0
  output logic      rx_fastlock_rc_oe,  // rx fast-lock pull-down enable
  output logic      programmed        // a complete load has been taken
);
  // link domain
  dps_word_t   shift_q;
  logic [5:0]  bit_cnt_q;
  // core domain
  logic [2:0]  le_sync_q;
  logic [2:0]  ok_sync_q;
  dps_word_t   word_q;
  logic        prog_q;
  logic        load_take;
  logic [10:0] ref_cnt_q;
  logic [10:0] ref_last;
  logic        ref_pulse;
  logic [4:0]  ref_code;
  logic [2:0]  thr_code;
  logic [1:0]  dz_code;
  logic [10:0] thr_cyc;
  logic [10:0] dz_cyc;
  logic [19:0] ext_cyc;
  logic [1:0]  osc_pin;
  logic [1:0]  main_out_q, main_oe_q, aux_out_q, aux_oe_q, unl_oe_q, fl_oe_q;

  always_ff @(posedge link.shift_strobe) begin
    shift_q <= {link.serial_in, shift_q[`DPS_WORD_BITS-1:1]};
  end

  // counter is cleared while framing is low, so a frame needs no strobe after it
  always_ff @(posedge link.shift_strobe or posedge rst or negedge link.load_enable) begin
    if (rst) begin
      bit_cnt_q <= 6'h00;
    end else if (!link.load_enable) begin
      bit_cnt_q <= 6'h00;
    end else if (bit_cnt_q != 6'h31) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      le_sync_q <= 3'h0;
      ok_sync_q <= 3'h0;
    end else begin
      le_sync_q <= {le_sync_q[1:0], link.load_enable};
      ok_sync_q <= {ok_sync_q[1:0], (bit_cnt_q == 6'h30)};
    end
  end
  // count flag piped as deep as framing, so both show one instant; word is quiet by then
  assign load_take = le_sync_q[2] & ~le_sync_q[1] & ok_sync_q[2];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_q <= '0;
      prog_q <= 1'b0;
    end else if (load_take) begin
      word_q <= shift_q;
      prog_q <= 1'b1;
    end
  end
  assign programmed = prog_q;
  assign ref_code = word_q[`DPS_REF_LSB +: 5];
  assign thr_code = word_q[`DPS_THR_LSB +: 3];
  assign dz_code  = word_q[`DPS_DZ_LSB +: 2];

  always_comb begin
    if (ref_code == `DPS_REF_CODE_HI) begin
      ref_last = `DPS_REF_RATIO_HI;
    end else begin
      ref_last = `DPS_REF_RATIO_LO;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_cnt_q <= 11'h000;
    end else if (load_take || ref_pulse) begin
      ref_cnt_q <= 11'h000;
    end else begin
      ref_cnt_q <= ref_cnt_q + 11'h001;
    end
  end
  assign ref_pulse = (ref_cnt_q == ref_last);

  // illegal code 3 maps to the smallest threshold of the column; 5 and 7 act as 4 and 6
  always_comb begin
    case (thr_code)
      3'h0:    thr_cyc = 11'h000;
      3'h1:    thr_cyc = XTAL_LOW ? 11'(`DPS_THR_B1_NS / `DPS_CLK_NS)
                                  : 11'(`DPS_THR_A1_NS / `DPS_CLK_NS);
      3'h2:    thr_cyc = XTAL_LOW ? 11'(`DPS_THR_B1_NS / `DPS_CLK_NS)
                                  : 11'(`DPS_THR_A2_NS / `DPS_CLK_NS);
      3'h4,
      3'h5:    thr_cyc = XTAL_LOW ? 11'(`DPS_THR_B4_NS / `DPS_CLK_NS)
                                  : 11'(`DPS_THR_A4_NS / `DPS_CLK_NS);
      3'h6,
      3'h7:    thr_cyc = XTAL_LOW ? 11'(`DPS_THR_B6_NS / `DPS_CLK_NS)
                                  : 11'(`DPS_THR_A6_NS / `DPS_CLK_NS);
      default: thr_cyc = XTAL_LOW ? 11'(`DPS_THR_B1_NS / `DPS_CLK_NS)
                                  : 11'(`DPS_THR_A1_NS / `DPS_CLK_NS);
    endcase
  end

  always_comb begin
    if (thr_code == 3'h0) begin
      ext_cyc = 20'h00000;
    end else if (word_q[`DPS_HOLD_BIT]) begin
      ext_cyc = 20'(EXT_LONG_CYC);
    end else begin
      ext_cyc = 20'(EXT_SHORT_CYC);
    end
  end

  // illegal dead-zone code behaves as the small band
  always_comb begin
    case (dz_code)
      2'h2:    dz_cyc = `DPS_DZ_MED_CYC;
      2'h3:    dz_cyc = `DPS_DZ_LARGE_CYC;
      default: dz_cyc = `DPS_DZ_SMALL_CYC;
    endcase
  end

  assign osc_pin = {rx_osc_in, tx_osc_in};

  // loop 0 is transmit, loop 1 is receive
  for (genvar i = 0; i < 2; i++) begin : g_loop
    logic [2:0]  osc_sync_q;
    logic [16:0] fb_cnt_q;
    logic [16:0] fb_last;
    logic        fb_pulse;
    logic        up_q, dn_q;
    logic [10:0] err_cnt_q;
    logic [19:0] hold_q;
    logic        exceed, unlocked, drive, fl_en;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        osc_sync_q <= 3'h0;
      end else begin
        osc_sync_q <= {osc_sync_q[1:0], osc_pin[i]};
      end
    end
    assign fb_last  = {word_q[`DPS_RXDIV_LSB*i +: 16], 1'b0} - 17'h00001;
    assign fb_pulse = osc_sync_q[1] & ~osc_sync_q[2] & (fb_cnt_q == fb_last);
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        fb_cnt_q <= 17'h00000;
      end else if (load_take || fb_pulse) begin
        fb_cnt_q <= 17'h00000;
      end else if (osc_sync_q[1] & ~osc_sync_q[2]) begin
        fb_cnt_q <= fb_cnt_q + 17'h00001;
      end
    end
    // tri-state detector: divided oscillator first means leading, reference first lagging
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        up_q <= 1'b0;
        dn_q <= 1'b0;
      end else if (fb_pulse && !ref_pulse) begin
        up_q <= ~dn_q;
        dn_q <= 1'b0;
      end else if (ref_pulse && !fb_pulse) begin
        dn_q <= ~up_q;
        up_q <= 1'b0;
      end
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        err_cnt_q <= 11'h000;
      end else if (!(up_q || dn_q)) begin
        err_cnt_q <= 11'h000;
      end else if (err_cnt_q != 11'h7ff) begin
        err_cnt_q <= err_cnt_q + 11'h001;
      end
    end
    assign exceed = (up_q || dn_q) && (err_cnt_q > thr_cyc);
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        hold_q <= 20'h00000;
      end else if (exceed) begin
        hold_q <= ext_cyc;
      end else if (hold_q != 20'h00000) begin
        hold_q <= hold_q - 20'h00001;
      end
    end
    assign unlocked = exceed || (hold_q != 20'h00000);
    assign drive    = (up_q || dn_q) && (err_cnt_q >= dz_cyc) && prog_q;
    assign fl_en    = word_q[`DPS_TXFL_BIT + i];
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        {main_out_q[i], main_oe_q[i], aux_out_q[i], aux_oe_q[i], unl_oe_q[i], fl_oe_q[i]} <= 6'h00;
      end else begin
        main_out_q[i] <= up_q;
        main_oe_q[i]  <= drive;
        aux_out_q[i]  <= up_q;
        aux_oe_q[i]   <= drive && unlocked;
        unl_oe_q[i]   <= prog_q && unlocked;
        fl_oe_q[i]    <= prog_q && fl_en && (word_q[`DPS_FLALL_BIT] || unlocked);
      end
    end
  end

  assign tx_pd_main_out     = main_out_q[0];
  assign tx_pd_main_oe      = main_oe_q[0];
  assign rx_pd_main_out     = main_out_q[1];
  assign rx_pd_main_oe      = main_oe_q[1];
  assign tx_pd_aux_out      = aux_out_q[0];
  assign tx_pd_aux_oe       = aux_oe_q[0];
  assign rx_pd_aux_out      = aux_out_q[1];
  assign rx_pd_aux_oe       = aux_oe_q[1];
  assign tx_unlock_n_out    = 1'b0;
  assign tx_unlock_n_oe     = unl_oe_q[0];
  assign rx_unlock_n_out    = 1'b0;
  assign rx_unlock_n_oe     = unl_oe_q[1];
  assign tx_fastlock_rc_out = 1'b0;
  assign tx_fastlock_rc_oe  = fl_oe_q[0];
  assign rx_fastlock_rc_out = 1'b0;
  assign rx_fastlock_rc_oe  = fl_oe_q[1];
endmodule
`default_nettype wire

// ### dps_host.sv
// Purpose: host end: assembles and shifts the 48-bit load word
// Assumes: clk is 200 MHz; strobe is made from it by the interval timer
// Notes:   every interval is held longer than 32 crystal periods of the slower crystal
`include "dps_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module dps_host
  import dps_pkg::*;
(
  input  wire logic        clk,                   // host clock
  input  wire logic        rst,                   // async reset, active high
  dps_if.host              link,                  // three-wire programming link
  input  wire logic        start,                 // pulse: load the fields below
  input  wire logic [15:0] tx_div_ratio,          // transmit divider setting
  input  wire logic [15:0] rx_div_ratio,          // receive divider setting
  input  wire logic [4:0]  ref_ratio_sel,         // reference divider code
  input  wire logic [2:0]  unlock_threshold_sel,  // phase-error threshold code
  input  wire logic        unlock_hold_sel,       // unlock extension select
  input  wire logic [1:0]  phase_insensitive_sel, // dead-zone code
  input  wire logic        tx_fastlock_en,        // tx fast-lock enable
  input  wire logic        rx_fastlock_en,        // rx fast-lock enable
  input  wire logic        fastlock_always,       // fast-lock continuous
  output logic             busy,                  // a load is in progress
  output logic             done                   // pulse: load finished
);
  localparam logic [9:0] T_CYC = 10'(`DPS_T_IFACE_CYC);

  dps_hstate_t state_q;
  dps_word_t   word_q;
  dps_word_t   word_d;
  logic [9:0]  tmr_q;
  logic [5:0]  bit_q;
  logic        le_q, stb_q, sd_q, done_q;
  logic        tmr_end;
  logic [15:0] tx_safe, rx_safe;

  // a setting below the legal floor is raised to it
  assign tx_safe = (tx_div_ratio < `DPS_DIV_MIN) ? `DPS_DIV_MIN : tx_div_ratio;
  assign rx_safe = (rx_div_ratio < `DPS_DIV_MIN) ? `DPS_DIV_MIN : rx_div_ratio;

  always_comb begin
    word_d = '0;
    word_d[`DPS_TXDIV_LSB +: 16] = tx_safe;
    word_d[`DPS_RXDIV_LSB +: 16] = rx_safe;
    word_d[`DPS_REF_LSB +: 5]    = ref_ratio_sel;
    word_d[`DPS_THR_LSB +: 3]    = unlock_threshold_sel;
    word_d[`DPS_HOLD_BIT]        = unlock_hold_sel;
    word_d[`DPS_DZ_LSB +: 2]     = phase_insensitive_sel;
    word_d[`DPS_TXFL_BIT]        = tx_fastlock_en;
    word_d[`DPS_RXFL_BIT]        = rx_fastlock_en;
    word_d[`DPS_FLALL_BIT]       = fastlock_always;
  end

  assign tmr_end = (tmr_q == 10'h000);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_q <= 10'h000;
    end else if ((state_q == DPS_IDLE && start) || (state_q != DPS_IDLE && tmr_end)) begin
      tmr_q <= T_CYC - 10'h001;
    end else if (!tmr_end) begin
      tmr_q <= tmr_q - 10'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= DPS_IDLE;
      word_q  <= '0;
      bit_q   <= 6'h00;
      le_q    <= 1'b0;
      stb_q   <= 1'b0;
      sd_q    <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        DPS_IDLE: begin
          if (start) begin
            word_q  <= word_d;
            bit_q   <= 6'h00;
            le_q    <= 1'b1;
            state_q <= DPS_LEAD;
          end
        end
        DPS_LEAD: begin
          if (tmr_end) begin
            sd_q    <= word_q[0];
            state_q <= DPS_SETUP;
          end
        end
        DPS_SETUP: begin
          if (tmr_end) begin
            stb_q   <= 1'b1;
            state_q <= DPS_HIGH;
          end
        end
        DPS_HIGH: begin
          if (tmr_end) begin
            stb_q  <= 1'b0;
            word_q <= {1'b0, word_q[`DPS_WORD_BITS-1:1]};
            bit_q  <= bit_q + 6'h01;
            if (bit_q == 6'(`DPS_WORD_BITS - 1)) begin
              state_q <= DPS_TAIL;
            end else begin
              sd_q    <= word_q[1];
              state_q <= DPS_SETUP;
            end
          end
        end
        DPS_TAIL: begin
          if (tmr_end) begin
            le_q    <= 1'b0;
            state_q <= DPS_GAP;
          end
        end
        DPS_GAP: begin
          if (tmr_end) begin
            done_q  <= 1'b1;
            state_q <= DPS_IDLE;
          end
        end
        default: state_q <= DPS_IDLE;
      endcase
    end
  end

  assign link.load_enable  = le_q;
  assign link.shift_strobe = stb_q;
  assign link.serial_in    = sd_q;
  assign busy              = (state_q != DPS_IDLE);
  assign done              = done_q;
endmodule
`default_nettype wire

// ### dps_if.sv
// Purpose: three-wire programming link between host and synthesizer
// Assumes: host drives all three wires
// Notes:   no clocking block; strobe is the device's link clock
`timescale 1ns/10ps
`default_nettype none
interface dps_if;
  logic load_enable;   // frame framing, high during a load
  logic shift_strobe;  // device samples serial_in on rising edge
  logic serial_in;     // serial data, first bit is tx divider bit 0
  modport host (output load_enable, output shift_strobe, output serial_in);
  modport dev  (input load_enable, input shift_strobe, input serial_in);
endinterface
`default_nettype wire

// ### dps_pkg.sv
// Purpose: shared types of the dual synthesizer serial control
// Assumes: nothing
// Notes:   constants live in dps_defs.svh
package dps_pkg;
  typedef enum logic [2:0] {
    DPS_IDLE, DPS_LEAD, DPS_SETUP, DPS_HIGH, DPS_TAIL, DPS_GAP
  } dps_hstate_t;
  typedef logic [47:0] dps_word_t;
endpackage

// ### dps_tb.sv
// Purpose: host and device joined over the link, one load checked end to end
// Assumes: one frame takes about 60k cycles, so only one full load fits
// Notes:   a second start while busy must be ignored, so one frame only
`timescale 1ns/10ps
`default_nettype none
module testbench
  import dps_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        start;
  logic        hold;
  logic        txe;
  logic        rxe;
  logic        fa;
  logic [15:0] txd;
  logic [15:0] rxd;
  logic [4:0]  refc;
  logic [2:0]  thr;
  logic [1:0]  dz;
  logic        busy;
  logic        done;
  logic        prog;
  wire logic [7:0] oo;
  wire logic [7:0] oe;
  logic [3:0]  oc = 4'h0;
  logic [31:0] seed;
  dps_word_t   cap;
  dps_word_t   exp_q[$];
  int          err_total;
  int          n_compared;
  int          i;

  dps_if link ();
  dps_host dps_host_i (.clk(clk), .rst(rst), .link(link), .start(start), .tx_div_ratio(txd),
    .rx_div_ratio(rxd), .ref_ratio_sel(refc), .unlock_threshold_sel(thr), .unlock_hold_sel(hold),
    .phase_insensitive_sel(dz), .tx_fastlock_en(txe), .rx_fastlock_en(rxe), .fastlock_always(fa),
    .busy(busy), .done(done));
  // short extensions keep the run small
  dps_device #(.EXT_SHORT_CYC(50), .EXT_LONG_CYC(100), .XTAL_LOW(1'b0)) dps_device_i (
    .clk(clk), .rst(rst), .link(link), .tx_osc_in(oc[2]), .rx_osc_in(oc[3]),
    .tx_pd_main_out(oo[0]), .tx_pd_main_oe(oe[0]), .rx_pd_main_out(oo[1]), .rx_pd_main_oe(oe[1]),
    .tx_pd_aux_out(oo[2]), .tx_pd_aux_oe(oe[2]), .rx_pd_aux_out(oo[3]), .rx_pd_aux_oe(oe[3]),
    .tx_unlock_n_out(oo[4]), .tx_unlock_n_oe(oe[4]), .rx_unlock_n_out(oo[5]), .rx_unlock_n_oe(oe[5]),
    .tx_fastlock_rc_out(oo[6]), .tx_fastlock_rc_oe(oe[6]), .rx_fastlock_rc_out(oo[7]),
    .rx_fastlock_rc_oe(oe[7]), .programmed(prog));
  dps_chk_sva dps_chk_sva_i (.clk(clk), .rst(rst), .load_enable(link.load_enable),
    .shift_strobe(link.shift_strobe), .serial_in(link.serial_in));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(negedge clk) oc <= oc + 4'h1;

  // watcher: bits arrive lsb first, word judged when the frame closes
  always @(posedge link.shift_strobe) if (link.load_enable === 1'b1) cap = {link.serial_in, cap[47:1]};
  always @(negedge link.load_enable) begin
    if (rst === 1'b0) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected frame");
      else chk(cap === exp_q.pop_front(), "load word");
    end
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    seed = 32'h649ac0aa;
    {rst, start, hold, txe, rxe, fa, txd, rxd, refc, thr, dz} = '0;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    seed = xs(seed);
    txd = seed[15:0] & 16'h00ff;
    rxd = seed[31:16];
    seed = xs(seed);
    refc = {5{seed[0]}};
    thr = seed[1] ? 3'h2 : 3'h1; // small threshold while the loops settle
    hold = seed[4];
    dz = seed[6:5];
    txe = 1'b1;
    fa = 1'b1;
    // tx setting below 256 goes out as 256
    exp_q.push_back({2'b00, fa, rxe, txe, dz, hold, thr, refc, (rxd < 16'h0100) ? 16'h0100 : rxd, 16'h0100});
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (20000) @(negedge clk);
    chk(prog === 1'b0 && oe === 8'h00, "outputs driven before load");
    chk(busy === 1'b1, "host idle in mid-frame");
    txd = 16'hffff;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (i = 0; i < 70000 && done !== 1'b1; i++) @(negedge clk);
    if (i == 70000) begin
      chk(1'b0, "load never finished");
      report_and_stop();
    end
    repeat (10) @(negedge clk);
    chk(prog === 1'b1, "not programmed after load");
    chk(oe[6] === 1'b1 && oo[6] === 1'b0, "tx fast-lock not on");
    chk(oe[7] === 1'b0, "rx fast-lock on while disabled");
    chk(exp_q.size() == 0, "frame missing");
    chk(busy === 1'b0, "host still busy after done");
    // both loops run far off lock here, so aux and unlock pins are exercised
    repeat (64) begin
      repeat (64) @(negedge clk);
      chk(oo[7:4] === 4'h0, "open-drain level not low");
      chk(!oe[2] || (oe[0] && oe[4] && oo[2] === oo[0]), "tx aux out of step with main");
      chk(!oe[3] || (oe[1] && oe[5] && oo[3] === oo[1]), "rx aux out of step with main");
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
